// File: clsbo_core.sv
// Execution unit for branches, bit operations, flag operations and memory loads and stores.
`timescale 1ns/1ps
// ==========================================================
// Contract
// - Overflow clear branch adds offset plus one.
// - Interrupt enabled branch adds offset plus one.
// - Interrupt disabled branch adds offset plus one.
// - Set I/O bit, two cycles, flags kept.
// - Clear I/O bit, two cycles, flags kept.
// - Rotate left through carry, flags ZCNV, one cycle.
// - Rotate right through carry, flags ZCNV, one cycle.
// - Copy register bit into T flag.
// - Copy T flag into register bit.
// - Set or clear one status flag.
// - Load indirect then increment pointer, two cycles.
// - Decrement pointer then load indirect, two cycles.
// - Load at Y or Z plus displacement.
// - Store indirect then increment pointer, two cycles.
// - Decrement pointer then store indirect, two cycles.
// - Store at Y or Z plus displacement.
// - Direct load from constant address, two cycles.
// - Direct store to constant address, two cycles.
// - Program memory load by Z, three cycles.
// - Extended load uses page above Z.
module clsbo_core #(
   parameter int PAGE_BITS = 2
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Instruction issue.
   input wire logic instr_valid,
   input wire clsbo_pkg::clsbo_op_t instr_op,
   input wire logic [1:0] instr_mode,
   input wire logic [1:0] instr_ptr,
   input wire logic [4:0] instr_rd,
   input wire logic [4:0] instr_rr,
   input wire logic [2:0] instr_bit,
   input wire logic [15:0] instr_k,
   output logic instr_ready,
   output logic [15:0] pc,
   // Data memory.
   output logic [15:0] dmem_addr,
   output logic [7:0] dmem_wdata,
   output logic dmem_re,
   output logic dmem_we,
   input wire logic [7:0] dmem_rdata,
   // Program memory.
   output logic [16+PAGE_BITS-1:0] pmem_addr,
   output logic pmem_re,
   input wire logic [7:0] pmem_rdata,
   // I/O bit access.
   output logic [4:0] io_addr,
   output logic [2:0] io_bit,
   output logic io_set,
   output logic io_clear,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);

   // ==========================================================
   // State and storage.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_BRANCH,
      ST_IO,
      ST_DLOAD,
      ST_DSTORE,
      ST_PM_ADDR,
      ST_PM_DATA
   } clsbo_state_t;

   // Current and next execution state.
   clsbo_state_t state;
   clsbo_state_t next_state;
   // Working registers.
   logic [7:0] gpr [32];
   // Status flags.
   logic [7:0] status_flags;
   // Program page extension, only the implemented bits.
   logic [PAGE_BITS-1:0] program_page_extension;
   // Destination register held for the second or third cycle.
   logic [4:0] rd_hold;

   // ==========================================================
   // Decode helpers.
   // Instruction accepted this cycle.
   logic accept;
   // Branch condition met.
   logic branch_cond;
   // Target of a taken branch.
   logic [15:0] branch_target;
   // Selected pointer pair index and value.
   logic [4:0] ptr_lo;
   logic [15:0] ptr_val;
   // Pointer value after update and effective data address.
   logic [15:0] ptr_new;
   logic [15:0] data_addr;
   // Full program address and its increment.
   logic [16+PAGE_BITS-1:0] prog_addr;
   logic [16+PAGE_BITS-1:0] prog_addr_inc;
   // Rotate result and new carry.
   logic [7:0] rot_result;
   logic rot_carry;
   // Register window hit on the register port.
   logic gpr_hit;

   assign accept = instr_valid && instr_ready;
   assign gpr_hit = (reg_addr[7:5] == clsbo_pkg::GPR_WINDOW_BASE[7:5]);
   assign ptr_lo = clsbo_pkg::PTR_BASE_REG + {2'h0, instr_ptr, 1'b0};
   assign ptr_val = {gpr[ptr_lo + 5'h01], gpr[ptr_lo]};
   assign prog_addr_inc = prog_addr + 1'b1;
   // Offset is sign extended and the branch skips past itself.
   assign branch_target = pc + {{(16 - clsbo_pkg::BRANCH_OFS_BITS)
      {instr_k[clsbo_pkg::BRANCH_OFS_BITS-1]}}, instr_k[clsbo_pkg::BRANCH_OFS_BITS-1:0]}
      + clsbo_pkg::PC_STEP_ONE;

   // Branch condition and rotate datapath.
   always_comb begin
      case (instr_op)
         clsbo_pkg::OP_BRANCH_NO_OVERFLOW: begin
            branch_cond = !status_flags[clsbo_pkg::FLAG_V];
         end
         clsbo_pkg::OP_BRANCH_IRQ_ON: begin
            branch_cond = status_flags[clsbo_pkg::FLAG_I];
         end
         clsbo_pkg::OP_BRANCH_IRQ_OFF: begin
            branch_cond = !status_flags[clsbo_pkg::FLAG_I];
         end
         default: begin
            branch_cond = 1'b0;
         end
      endcase
      // Left rotate brings carry into bit 0, right rotate into bit 7.
      if (instr_op == clsbo_pkg::OP_ROTATE_LEFT_CARRY) begin
         rot_result = {gpr[instr_rd][6:0], status_flags[clsbo_pkg::FLAG_C]};
         rot_carry = gpr[instr_rd][7];
      end else begin
         rot_result = {status_flags[clsbo_pkg::FLAG_C], gpr[instr_rd][7:1]};
         rot_carry = gpr[instr_rd][0];
      end
   end

   // Pointer arithmetic and effective addresses.
   always_comb begin
      ptr_new = ptr_val;
      data_addr = ptr_val;
      case (instr_mode)
         clsbo_pkg::AM_POSTINC: begin
            ptr_new = ptr_val + clsbo_pkg::PC_STEP_ONE;
         end
         clsbo_pkg::AM_PREDEC: begin
            ptr_new = ptr_val - clsbo_pkg::PC_STEP_ONE;
            data_addr = ptr_new;
         end
         clsbo_pkg::AM_DISP: begin
            // Pointer is left alone, only the address is offset.
            data_addr = ptr_val + {10'h000, instr_k[clsbo_pkg::DISP_BITS-1:0]};
         end
         default: begin
            data_addr = ptr_val;
         end
      endcase
      // The page extension sits above Z only for the extended form.
      if (instr_op == clsbo_pkg::OP_EXTENDED_PROGRAM_MEMORY_LOAD) begin
         prog_addr = {program_page_extension,
            gpr[clsbo_pkg::PTR_Z_LOW_REG + 5'h01], gpr[clsbo_pkg::PTR_Z_LOW_REG]};
      end else begin
         prog_addr = {{PAGE_BITS{1'b0}},
            gpr[clsbo_pkg::PTR_Z_LOW_REG + 5'h01], gpr[clsbo_pkg::PTR_Z_LOW_REG]};
      end
   end

   // ==========================================================
   // Sequencing.
   // Next state: multi-cycle instructions leave idle on acceptance.
   always_comb begin
      next_state = ST_IDLE;
      case (state)
         ST_IDLE: begin
            if (accept) begin
               case (instr_op)
                  clsbo_pkg::OP_BRANCH_NO_OVERFLOW,
                  clsbo_pkg::OP_BRANCH_IRQ_ON,
                  clsbo_pkg::OP_BRANCH_IRQ_OFF: begin
                     // Taken branch spends one more cycle to refetch.
                     next_state = branch_cond ? ST_BRANCH : ST_IDLE;
                  end
                  clsbo_pkg::OP_SET_IO_BIT, clsbo_pkg::OP_CLEAR_IO_BIT: begin
                     next_state = ST_IO;
                  end
                  clsbo_pkg::OP_LOAD_INDIRECT, clsbo_pkg::OP_LOAD_DIRECT: begin
                     next_state = ST_DLOAD;
                  end
                  clsbo_pkg::OP_STORE_INDIRECT, clsbo_pkg::OP_STORE_DIRECT: begin
                     next_state = ST_DSTORE;
                  end
                  clsbo_pkg::OP_PROGRAM_MEMORY_LOAD,
                  clsbo_pkg::OP_EXTENDED_PROGRAM_MEMORY_LOAD: begin
                     next_state = ST_PM_ADDR;
                  end
                  default: begin
                     next_state = ST_IDLE;
                  end
               endcase
            end
         end
         ST_PM_ADDR: begin
            next_state = ST_PM_DATA;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // State register and the ready flag that mirrors it.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         instr_ready <= 1'b1;
      end else begin
         state <= next_state;
         instr_ready <= (next_state == ST_IDLE);
      end
   end

   // Program counter: one word per instruction, two for direct accesses, offset plus one for taken branches.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc <= 16'h0000;
      end else if (accept) begin
         if (branch_cond) begin
            pc <= branch_target;
         end else if (instr_op == clsbo_pkg::OP_LOAD_DIRECT ||
               instr_op == clsbo_pkg::OP_STORE_DIRECT) begin
            pc <= pc + clsbo_pkg::PC_STEP_TWO;
         end else begin
            pc <= pc + clsbo_pkg::PC_STEP_ONE;
         end
      end
   end

   // ==========================================================
   // Memory and I/O strobes, each standing for one cycle.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dmem_addr <= 16'h0000;
         dmem_wdata <= 8'h00;
         dmem_re <= 1'b0;
         dmem_we <= 1'b0;
         pmem_addr <= '0;
         pmem_re <= 1'b0;
         io_addr <= 5'h00;
         io_bit <= 3'h0;
         io_set <= 1'b0;
         io_clear <= 1'b0;
         rd_hold <= 5'h00;
      end else begin
         dmem_re <= accept && (instr_op == clsbo_pkg::OP_LOAD_INDIRECT ||
            instr_op == clsbo_pkg::OP_LOAD_DIRECT);
         dmem_we <= accept && (instr_op == clsbo_pkg::OP_STORE_INDIRECT ||
            instr_op == clsbo_pkg::OP_STORE_DIRECT);
         pmem_re <= accept && (instr_op == clsbo_pkg::OP_PROGRAM_MEMORY_LOAD ||
            instr_op == clsbo_pkg::OP_EXTENDED_PROGRAM_MEMORY_LOAD);
         io_set <= accept && (instr_op == clsbo_pkg::OP_SET_IO_BIT);
         io_clear <= accept && (instr_op == clsbo_pkg::OP_CLEAR_IO_BIT);
         if (accept) begin
            rd_hold <= instr_rd;
            io_addr <= instr_k[4:0];
            io_bit <= instr_bit;
            dmem_wdata <= gpr[instr_rr];
            pmem_addr <= prog_addr;
            // Direct forms carry the address in the instruction.
            if (instr_op == clsbo_pkg::OP_LOAD_DIRECT ||
                  instr_op == clsbo_pkg::OP_STORE_DIRECT) begin
               dmem_addr <= instr_k;
            end else begin
               dmem_addr <= data_addr;
            end
         end
      end
   end

   // ==========================================================
   // Working registers: port writes, results and pointer updates.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 32; i++) begin
            gpr[i] <= 8'h00;
         end
      end else begin
         if (reg_wr && gpr_hit) begin
            gpr[reg_addr[4:0]] <= reg_wdata;
         end
         if (accept) begin
            case (instr_op)
               clsbo_pkg::OP_ROTATE_LEFT_CARRY, clsbo_pkg::OP_ROTATE_RIGHT_CARRY: begin
                  gpr[instr_rd] <= rot_result;
               end
               clsbo_pkg::OP_T_FLAG_TO_BIT: begin
                  gpr[instr_rd][instr_bit] <= status_flags[clsbo_pkg::FLAG_T];
               end
               clsbo_pkg::OP_LOAD_INDIRECT, clsbo_pkg::OP_STORE_INDIRECT: begin
                  // Plain and displaced forms write the pointer back unchanged.
                  gpr[ptr_lo] <= ptr_new[7:0];
                  gpr[ptr_lo + 5'h01] <= ptr_new[15:8];
               end
               clsbo_pkg::OP_PROGRAM_MEMORY_LOAD,
               clsbo_pkg::OP_EXTENDED_PROGRAM_MEMORY_LOAD: begin
                  if (instr_mode == clsbo_pkg::AM_POSTINC) begin
                     gpr[clsbo_pkg::PTR_Z_LOW_REG] <= prog_addr_inc[7:0];
                     gpr[clsbo_pkg::PTR_Z_LOW_REG + 5'h01] <= prog_addr_inc[15:8];
                  end
               end
               default: begin
               end
            endcase
         end
         // Loaded bytes land at the end of the last cycle.
         if (state == ST_DLOAD) begin
            gpr[rd_hold] <= dmem_rdata;
         end
         if (state == ST_PM_DATA) begin
            gpr[rd_hold] <= pmem_rdata;
         end
      end
   end

   // Page extension: the extended post-increment carries into it.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         program_page_extension <= clsbo_pkg::PAGE_EXT_RESET[PAGE_BITS-1:0];
      end else if (accept && instr_mode == clsbo_pkg::AM_POSTINC &&
            instr_op == clsbo_pkg::OP_EXTENDED_PROGRAM_MEMORY_LOAD) begin
         program_page_extension <= prog_addr_inc[16+PAGE_BITS-1:16];
      end else if (reg_wr && reg_addr == clsbo_pkg::PAGE_EXT_ADDR) begin
         program_page_extension <= reg_wdata[PAGE_BITS-1:0];
      end
   end

   // Status flags: instruction updates win over a port write.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_flags <= clsbo_pkg::STATUS_FLAGS_RESET;
      end else begin
         if (reg_wr && reg_addr == clsbo_pkg::STATUS_FLAGS_ADDR) begin
            status_flags <= reg_wdata;
         end
         if (accept) begin
            case (instr_op)
               clsbo_pkg::OP_ROTATE_LEFT_CARRY, clsbo_pkg::OP_ROTATE_RIGHT_CARRY: begin
                  // Overflow is negative xor carry after the rotate.
                  status_flags[clsbo_pkg::FLAG_C] <= rot_carry;
                  status_flags[clsbo_pkg::FLAG_Z] <= (rot_result == 8'h00);
                  status_flags[clsbo_pkg::FLAG_N] <= rot_result[7];
                  status_flags[clsbo_pkg::FLAG_V] <= rot_result[7] ^ rot_carry;
               end
               clsbo_pkg::OP_BIT_TO_T_FLAG: begin
                  status_flags[clsbo_pkg::FLAG_T] <= gpr[instr_rr][instr_bit];
               end
               clsbo_pkg::OP_GENERIC_FLAG_SET: begin
                  status_flags[instr_bit] <= 1'b1;
               end
               clsbo_pkg::OP_GENERIC_FLAG_CLEAR: begin
                  status_flags[instr_bit] <= 1'b0;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Register port read data, valid in the cycle after the strobe.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == clsbo_pkg::STATUS_FLAGS_ADDR) begin
         reg_rdata <= status_flags;
      end else if (reg_addr == clsbo_pkg::PAGE_EXT_ADDR) begin
         reg_rdata <= {{(8-PAGE_BITS){1'b0}}, program_page_extension};
      end else if (gpr_hit) begin
         reg_rdata <= gpr[reg_addr[4:0]];
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ==========================================================
   // Assertions and covers.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // Operation being accepted, for readable assertions.
   logic is_br;
   logic is_dir;
   assign is_br = (instr_op == clsbo_pkg::OP_BRANCH_NO_OVERFLOW) ||
      (instr_op == clsbo_pkg::OP_BRANCH_IRQ_ON) || (instr_op == clsbo_pkg::OP_BRANCH_IRQ_OFF);
   assign is_dir = (instr_op == clsbo_pkg::OP_LOAD_DIRECT) ||
      (instr_op == clsbo_pkg::OP_STORE_DIRECT);

   a_overflow_branch: assert property (
      accept && instr_op == clsbo_pkg::OP_BRANCH_NO_OVERFLOW && !status_flags[clsbo_pkg::FLAG_V]
      |=> pc == $past(branch_target)) else $error("overflow branch target wrong");
   a_irq_on_branch: assert property (
      accept && instr_op == clsbo_pkg::OP_BRANCH_IRQ_ON && status_flags[clsbo_pkg::FLAG_I]
      |=> !instr_ready ##1 instr_ready) else $error("irq on branch timing wrong");
   a_irq_off_branch: assert property (
      accept && instr_op == clsbo_pkg::OP_BRANCH_IRQ_OFF && status_flags[clsbo_pkg::FLAG_I]
      |=> instr_ready && pc == $past(pc) + 16'h0001) else $error("irq off branch not skipped");
   a_branch_cycles: assert property (
      accept && is_br && !branch_cond |=> instr_ready) else $error("untaken branch stalled");
   a_io_set_pulse: assert property (
      accept && instr_op == clsbo_pkg::OP_SET_IO_BIT && !reg_wr
      |=> io_set && io_bit == $past(instr_bit) && status_flags == $past(status_flags)
      ##1 !io_set && instr_ready) else $error("set io bit sequence wrong");
   a_io_clear_pulse: assert property (
      accept && instr_op == clsbo_pkg::OP_CLEAR_IO_BIT
      |=> io_clear && !io_set ##1 !io_clear) else $error("clear io bit sequence wrong");
   a_rotate_left: assert property (
      accept && instr_op == clsbo_pkg::OP_ROTATE_LEFT_CARRY && !reg_wr
      |=> status_flags[clsbo_pkg::FLAG_C] == $past(gpr[instr_rd][7]) && instr_ready)
      else $error("rotate left carry wrong");
   a_rotate_right: assert property (
      accept && instr_op == clsbo_pkg::OP_ROTATE_RIGHT_CARRY && !reg_wr
      |=> status_flags[clsbo_pkg::FLAG_C] == $past(gpr[instr_rd][0])
      && status_flags[clsbo_pkg::FLAG_N] == $past(status_flags[clsbo_pkg::FLAG_C]))
      else $error("rotate right flags wrong");
   a_t_flag_store: assert property (
      accept && instr_op == clsbo_pkg::OP_BIT_TO_T_FLAG && !reg_wr
      |=> status_flags[clsbo_pkg::FLAG_T] == $past(gpr[instr_rr][instr_bit]))
      else $error("bit not copied to T");
   a_flag_set: assert property (
      accept && instr_op == clsbo_pkg::OP_GENERIC_FLAG_SET && !reg_wr
      |=> status_flags[$past(instr_bit)]) else $error("flag not set");
   a_load_cycles: assert property (
      accept && instr_op == clsbo_pkg::OP_LOAD_INDIRECT
      |=> dmem_re && !instr_ready ##1 !dmem_re && instr_ready) else $error("load not two cycles");
   a_predec_addr: assert property (
      accept && instr_op == clsbo_pkg::OP_STORE_INDIRECT && instr_mode == clsbo_pkg::AM_PREDEC
      |=> dmem_we && dmem_addr == $past(ptr_val) - 16'h0001) else $error("predec address wrong");
   a_direct_pc: assert property (
      accept && is_dir |=> pc == $past(pc) + 16'h0002 && dmem_addr == $past(instr_k))
      else $error("direct access pc or address wrong");
   a_pm_cycles: assert property (
      accept && instr_op == clsbo_pkg::OP_PROGRAM_MEMORY_LOAD
      |=> pmem_re && !instr_ready ##1 !pmem_re && !instr_ready ##1 instr_ready)
      else $error("program load not three cycles");

   c_taken_branch: cover property (accept && is_br && branch_cond);
   c_indirect_load: cover property (accept && instr_op == clsbo_pkg::OP_LOAD_INDIRECT);
   c_ext_pm_inc: cover property (accept && instr_mode == clsbo_pkg::AM_POSTINC &&
      instr_op == clsbo_pkg::OP_EXTENDED_PROGRAM_MEMORY_LOAD);

endmodule

// File: clsbo_mem_model.sv
// Far-side model: data memory, program memory and I/O registers.
`timescale 1ns/1ps
module clsbo_mem_model (
   // Clock.
   input wire logic core_clk,
   // Data memory side.
   input wire logic [15:0] dmem_addr,
   input wire logic [7:0] dmem_wdata,
   input wire logic dmem_re,
   input wire logic dmem_we,
   output logic [7:0] dmem_rdata,
   // Program memory side.
   input wire logic [17:0] pmem_addr,
   input wire logic pmem_re,
   output logic [7:0] pmem_rdata,
   // I/O bit side.
   input wire logic [4:0] io_addr,
   input wire logic [2:0] io_bit,
   input wire logic io_set,
   input wire logic io_clear
);
   logic [7:0] dm [256];
   logic [7:0] io [32];
   logic [7:0] last = 8'h00;
   // An idle data bus shows the inverse of the last byte, never a stale copy.
   assign dmem_rdata = dmem_re ? dm[dmem_addr[7:0]] : ~last;
   // Writes, bit updates and the synchronous program read.
   always @(posedge core_clk) begin
      if (dmem_re) last <= dm[dmem_addr[7:0]];
      if (dmem_we) dm[dmem_addr[7:0]] <= dmem_wdata;
      if (io_set) io[io_addr][io_bit] <= 1'b1;
      if (io_clear) io[io_addr][io_bit] <= 1'b0;
      pmem_rdata <= pmem_re ? pmem_addr[7:0] ^ {6'h00, pmem_addr[17:16]} : ~pmem_rdata;
   end
endmodule

// File: clsbo_pkg.sv
// Constants, opcodes and register map for the load, store and bit operation unit.
package clsbo_pkg;

   // ==========================================================
   // Register map of the plain register port.
   // Status flags register offset.
   localparam logic [7:0] STATUS_FLAGS_ADDR = 8'h3F;
   // Program page extension register offset.
   localparam logic [7:0] PAGE_EXT_ADDR = 8'h3B;
   // First offset of the working register window (32 bytes).
   localparam logic [7:0] GPR_WINDOW_BASE = 8'h40;
   // Reset value of the status flags.
   localparam logic [7:0] STATUS_FLAGS_RESET = 8'h00;
   // Reset value of the page extension register.
   localparam logic [7:0] PAGE_EXT_RESET = 8'h00;

   // ==========================================================
   // Bit positions inside the status flags.
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // ==========================================================
   // Pointer register pairs and their low register index.
   localparam logic [1:0] PTR_X = 2'h0;
   localparam logic [1:0] PTR_Y = 2'h1;
   localparam logic [1:0] PTR_Z = 2'h2;
   localparam logic [4:0] PTR_BASE_REG = 5'h1A;
   localparam logic [4:0] PTR_Z_LOW_REG = 5'h1E;

   // ==========================================================
   // Addressing modes for indirect and program memory accesses.
   localparam logic [1:0] AM_PLAIN = 2'h0;
   localparam logic [1:0] AM_POSTINC = 2'h1;
   localparam logic [1:0] AM_PREDEC = 2'h2;
   localparam logic [1:0] AM_DISP = 2'h3;

   // ==========================================================
   // Encoding: branch offset width, displacement width, instruction words.
   localparam int BRANCH_OFS_BITS = 7;
   localparam int DISP_BITS = 6;
   localparam logic [15:0] PC_STEP_ONE = 16'h0001;
   localparam logic [15:0] PC_STEP_TWO = 16'h0002;

   // Operations handled by this unit.
   typedef enum logic [4:0] {
      OP_NOP,
      OP_BRANCH_NO_OVERFLOW,
      OP_BRANCH_IRQ_ON,
      OP_BRANCH_IRQ_OFF,
      OP_SET_IO_BIT,
      OP_CLEAR_IO_BIT,
      OP_ROTATE_LEFT_CARRY,
      OP_ROTATE_RIGHT_CARRY,
      OP_BIT_TO_T_FLAG,
      OP_T_FLAG_TO_BIT,
      OP_GENERIC_FLAG_SET,
      OP_GENERIC_FLAG_CLEAR,
      OP_LOAD_INDIRECT,
      OP_STORE_INDIRECT,
      OP_LOAD_DIRECT,
      OP_STORE_DIRECT,
      OP_PROGRAM_MEMORY_LOAD,
      OP_EXTENDED_PROGRAM_MEMORY_LOAD
   } clsbo_op_t;

endpackage

// File: cpu_load_store_bit_ops_tb.sv
// Self-checking bench for the load, store and bit operation unit.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module cpu_load_store_bit_ops_tb;
   logic core_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   clsbo_pkg::clsbo_op_t instr_op = clsbo_pkg::OP_NOP;
   logic [1:0] instr_mode = 2'h0, instr_ptr = clsbo_pkg::PTR_X;
   logic [4:0] instr_rd = 5'h00, instr_rr = 5'h00, io_addr;
   logic [2:0] instr_bit = 3'h0, io_bit;
   logic [15:0] instr_k = 16'h0000, pc, dmem_addr, p0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, dmem_wdata, dmem_rdata;
   logic [7:0] pmem_rdata, d;
   logic [17:0] pmem_addr;
   logic instr_ready, dmem_re, dmem_we, pmem_re, io_set, io_clear, rdy;
   int miscompares = 0, compares = 0;
   initial forever #10 core_clk = ~core_clk;
   clsbo_core i_clsbo_core (.core_clk, .rst_n, .instr_valid, .instr_op, .instr_mode,
      .instr_ptr, .instr_rd, .instr_rr, .instr_bit, .instr_k, .instr_ready, .pc, .dmem_addr,
      .dmem_wdata, .dmem_re, .dmem_we, .dmem_rdata, .pmem_addr, .pmem_re, .pmem_rdata,
      .io_addr, .io_bit, .io_set, .io_clear, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata);
   clsbo_mem_model i_clsbo_mem_model (.core_clk, .dmem_addr, .dmem_wdata, .dmem_re,
      .dmem_we, .dmem_rdata, .pmem_addr, .pmem_re, .pmem_rdata, .io_addr, .io_bit, .io_set,
      .io_clear);
   // Register port write and read, one strobe cycle each.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Issues one instruction, samples ready after acceptance, lets it finish.
   task automatic ex(input clsbo_pkg::clsbo_op_t op, input logic [1:0] m,
      input logic [4:0] r, input logic [2:0] b, input logic [15:0] k);
      @(posedge core_clk);
      instr_op <= op;
      instr_mode <= m;
      instr_rd <= r;
      instr_rr <= r;
      instr_bit <= b;
      instr_k <= k;
      instr_valid <= 1'b1;
      @(posedge core_clk);
      instr_valid <= 1'b0;
      #1 rdy = instr_ready;
      repeat (3) @(posedge core_clk);
   endtask
   // Branch by minus two: taken lands on pc minus one and drops ready once.
   task automatic br(input clsbo_pkg::clsbo_op_t op, input logic t);
      p0 = pc;
      ex(op, 2'h0, 5'h00, 3'h0, 16'h007E);
      `CHK("branch pc", t ? p0 - 16'h0001 : p0 + 16'h0001, pc)
      `CHK("branch ready", !t, rdy)
   endtask
   task automatic end_sim;
      if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #50000;
      miscompares++;
      end_sim;
   end
   initial begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(8'h3F, d); `CHK("flags reset", clsbo_pkg::STATUS_FLAGS_RESET, d)
      rd(8'h10, d); `CHK("unmapped", 8'h00, d)
      for (int i = 0; i < 8; i++) begin
         ex(clsbo_pkg::OP_GENERIC_FLAG_SET, 2'h0, 5'h00, 3'(i), 16'h0000);
         rd(8'h3F, d); `CHK("flag set", 8'((2 << i) - 1), d)
      end
      br(clsbo_pkg::OP_BRANCH_IRQ_ON, 1'b1);
      br(clsbo_pkg::OP_BRANCH_IRQ_OFF, 1'b0);
      br(clsbo_pkg::OP_BRANCH_NO_OVERFLOW, 1'b0);
      for (int i = 0; i < 8; i++) begin
         ex(clsbo_pkg::OP_GENERIC_FLAG_CLEAR, 2'h0, 5'h00, 3'(i), 16'h0000);
         rd(8'h3F, d); `CHK("flag clear", 8'(8'hFF << (i + 1)), d)
      end
      br(clsbo_pkg::OP_BRANCH_NO_OVERFLOW, 1'b1);
      br(clsbo_pkg::OP_BRANCH_IRQ_OFF, 1'b1);
      br(clsbo_pkg::OP_BRANCH_IRQ_ON, 1'b0);
      wr(8'h50, 8'h81);
      ex(clsbo_pkg::OP_GENERIC_FLAG_SET, 2'h0, 5'h00, 3'h0, 16'h0000);
      ex(clsbo_pkg::OP_ROTATE_LEFT_CARRY, 2'h0, 5'h10, 3'h0, 16'h0000);
      rd(8'h50, d); `CHK("rol", 8'h03, d)
      rd(8'h3F, d); `CHK("rol flags", 8'h09, d)
      ex(clsbo_pkg::OP_ROTATE_RIGHT_CARRY, 2'h0, 5'h10, 3'h0, 16'h0000);
      rd(8'h50, d); `CHK("ror", 8'h81, d)
      rd(8'h3F, d); `CHK("ror flags", 8'h05, d)
      ex(clsbo_pkg::OP_BIT_TO_T_FLAG, 2'h0, 5'h10, 3'h7, 16'h0000);
      wr(8'h51, 8'h00);
      ex(clsbo_pkg::OP_T_FLAG_TO_BIT, 2'h0, 5'h11, 3'h2, 16'h0000);
      rd(8'h51, d); `CHK("t to bit", 8'h04, d)
      ex(clsbo_pkg::OP_SET_IO_BIT, 2'h0, 5'h00, 3'h3, 16'h0005);
      `CHK("io set", 1'b1, i_clsbo_mem_model.io[5][3])
      rd(8'h3F, d); `CHK("t flag", 8'h45, d)
      ex(clsbo_pkg::OP_CLEAR_IO_BIT, 2'h0, 5'h00, 3'h3, 16'h0005);
      `CHK("io clear", 1'b0, i_clsbo_mem_model.io[5][3])
      wr(8'h5A, 8'h10);
      wr(8'h5B, 8'h00);
      ex(clsbo_pkg::OP_STORE_INDIRECT, clsbo_pkg::AM_POSTINC, 5'h10, 3'h0, 16'h0000);
      rd(8'h5A, d); `CHK("x inc", 8'h11, d)
      ex(clsbo_pkg::OP_LOAD_INDIRECT, clsbo_pkg::AM_PREDEC, 5'h12, 3'h0, 16'h0000);
      rd(8'h52, d); `CHK("load", 8'h81, d)
      rd(8'h5A, d); `CHK("x dec", 8'h10, d)
      ex(clsbo_pkg::OP_STORE_DIRECT, 2'h0, 5'h11, 3'h0, 16'h0020);
      ex(clsbo_pkg::OP_LOAD_DIRECT, 2'h0, 5'h13, 3'h0, 16'h0020);
      rd(8'h53, d); `CHK("direct", 8'h04, d)
      wr(8'h3B, 8'hFE);
      rd(8'h3B, d); `CHK("page", 8'h02, d)
      wr(8'h5E, 8'h34);
      wr(8'h5F, 8'h12);
      ex(clsbo_pkg::OP_EXTENDED_PROGRAM_MEMORY_LOAD, clsbo_pkg::AM_POSTINC, 5'h14, 3'h0,
         16'h0000);
      rd(8'h54, d); `CHK("ext load", 8'h36, d)
      rd(8'h5E, d); `CHK("z inc", 8'h35, d)
      instr_ptr <= 2'h2;
      ex(clsbo_pkg::OP_PROGRAM_MEMORY_LOAD, 2'h0, 5'h15, 3'h0, 16'h0000);
      rd(8'h55, d); `CHK("pm load", 8'h35, d)
      ex(clsbo_pkg::OP_STORE_INDIRECT, 2'h3, 5'h15, 3'h0, 16'h0003);
      ex(clsbo_pkg::OP_LOAD_INDIRECT, 2'h3, 5'h16, 3'h0, 16'h0003);
      rd(8'h56, d); `CHK("disp", 8'h35, d)
      ex(clsbo_pkg::OP_STORE_INDIRECT, 2'h2, 5'h16, 3'h0, 16'h0000);
      rd(8'h5E, d); `CHK("z dec", 8'h34, d)
      end_sim;
   end
endmodule
